// ---- pkg/sew_pkg.sv ----
// Shared constants and enumerations for the two-wire EEPROM write path
package sew_pkg;
  // Fixed upper nibble of every device address word
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  // Density variants
  localparam int VARIANT_2K = 0;
  localparam int VARIANT_4K = 1;
  localparam int VARIANT_8K = 2;
  localparam int VARIANT_16K = 3;
  // Word address and page geometry
  localparam int BASE_ADDR_BITS = 8;
  localparam int MAX_ADDR_BITS = 11;
  localparam int PAGE_BITS_2K = 3;
  localparam int PAGE_BITS_WIDE = 4;
  // Bit counter positions within a nine-clock word
  localparam logic [3:0] ACK_BIT_IDX = 4'h8;
  localparam logic [3:0] ACK_END_IDX = 4'h9;
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SELF_TIMED_PROGRAM_TIME_US = 3000;
  localparam int PROG_CYC = SELF_TIMED_PROGRAM_TIME_US * CLK_MHZ;
  localparam int SCL_QUARTER_NS = 250;
  localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_PULSES = 9;
  // Synchroniser reset levels: scl, sda, protect high; selects low
  localparam logic [5:0] DEV_PIN_INIT = 6'h38;
  localparam logic CTL_SDA_INIT = 1'h1;

  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_DEVADR = 3'h1,
    D_WORDADR = 3'h2,
    D_DATA = 3'h3,
    D_READ = 3'h4,
    D_PROG = 3'h5
  } sew_dst_t;

  typedef enum logic [2:0] {
    C_IDLE = 3'h0,
    C_HOLD = 3'h1,
    C_START = 3'h2,
    C_BIT = 3'h3,
    C_STOP = 3'h4,
    C_RECOV = 3'h5
  } sew_cst_t;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_BYTE = 2'h1,
    OP_STOP = 2'h2,
    OP_RECOVER = 2'h3
  } sew_op_t;
endpackage : sew_pkg

// ---- pkg/sew_if.sv ----
// Two-wire link between the EEPROM target end and the bus controller end
`timescale 1ns/1ps
`default_nettype none
interface sew_if;
  logic scl;
  logic sda;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic ctl_sda_o;
  logic ctl_sda_oe_n;
  // Open-drain wired-AND with pull-up
  assign sda = ~((~dev_sda_oe_n & ~dev_sda_o) | (~ctl_sda_oe_n & ~ctl_sda_o));
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport ctl (output scl, output ctl_sda_o, output ctl_sda_oe_n, input sda);
endinterface : sew_if
`default_nettype wire

// ---- rtl/sew_sync.sv ----
// Two-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module sew_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      meta_q <= INIT;
      sync_q <= INIT;
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule // sew_sync
`default_nettype wire

// ---- rtl/sew_bus_ctl.sv ----
// Two-wire bus controller end: start, stop, byte transfer and bus recovery
`timescale 1ns/1ps
`default_nettype none
module sew_bus_ctl #(
  parameter int QUARTER_CYC = sew_pkg::SCL_QUARTER_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  sew_if.ctl bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sew_pkg::sew_op_t cmd_op,
  input wire logic [7:0] cmd_byte,
  output logic rsp_valid,
  output logic rsp_ack,
  output logic bus_idle
);
  import sew_pkg::*;

  localparam int DW = $clog2(QUARTER_CYC + 1);

  generate
    if (QUARTER_CYC < 2)
    begin : g_bad_param
      $error("sew_bus_ctl: QUARTER_CYC too small");
    end
  endgenerate

  sew_cst_t st_q;
  sew_cst_t st_d;
  logic sda_s;
  logic [DW-1:0] div_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [3:0] rec_q;
  logic [7:0] sh_q;
  logic scl_q;
  logic scl_d;
  logic sda_low_q;
  logic sda_low_d;
  logic rsp_valid_q;
  logic rsp_ack_q;
  logic bus_idle_q;

  sew_sync #(.W(1), .INIT(CTL_SDA_INIT)) u_sda_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d(bus.sda),
    .q(sda_s)
  );

  wire held = st_q == C_HOLD;
  wire take = cmd_valid & cmd_ready;
  wire tick = div_q == DW'(QUARTER_CYC - 1);
  wire ph_end = tick & (ph_q == 2'h3);
  wire last_bit = bit_q == ACK_BIT_IDX;
  wire rec_end = rec_q == 4'(RECOVER_PULSES - 1);
  wire nack_cmd = take & ~held & ((cmd_op == OP_BYTE) | (cmd_op == OP_STOP));

  // Phase plan per quarter: byte data moves only while the clock is low; start and stop move data with the clock high
  always_comb
  begin
    st_d = st_q;
    scl_d = scl_q;
    sda_low_d = sda_low_q;
    case (st_q)
      C_IDLE, C_HOLD:
      begin
        if (take && cmd_op == OP_START)
          st_d = C_START;
        else if (take && cmd_op == OP_RECOVER)
          st_d = C_RECOV;
        else if (take && held && cmd_op == OP_BYTE)
          st_d = C_BIT;
        else if (take && held && cmd_op == OP_STOP)
          st_d = C_STOP;
      end
      C_START:
      begin
        if (tick && ph_q == 2'h0)
          sda_low_d = 1'b0;
        if (tick && ph_q == 2'h1)
          scl_d = 1'b1;
        if (tick && ph_q == 2'h2)
          sda_low_d = 1'b1;
        if (ph_end)
        begin
          scl_d = 1'b0;
          st_d = C_BIT;
        end
      end
      C_BIT:
      begin
        if (tick && ph_q == 2'h0)
          sda_low_d = ~last_bit & ~sh_q[7];
        if (tick && ph_q == 2'h2)
          scl_d = 1'b1;
        if (ph_end)
          scl_d = 1'b0;
        if (ph_end && last_bit)
          st_d = C_HOLD;
      end
      C_STOP:
      begin
        if (tick && ph_q == 2'h0)
          sda_low_d = 1'b1;
        if (tick && ph_q == 2'h1)
          scl_d = 1'b1;
        if (tick && ph_q == 2'h2)
          sda_low_d = 1'b0;
        if (ph_end)
          st_d = C_IDLE;
      end
      C_RECOV:
      begin
        if (tick && ph_q == 2'h0)
        begin
          scl_d = 1'b0;
          sda_low_d = 1'b0;
        end
        if (tick && ph_q == 2'h2)
          scl_d = 1'b1;
        if (ph_end && sda_s)
          st_d = C_START;
        else if (ph_end)
        begin
          scl_d = 1'b0;
          st_d = rec_end ? C_HOLD : C_RECOV;
        end
      end
      default:
      begin
        st_d = C_IDLE;
        scl_d = 1'b1;
        sda_low_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_q <= C_IDLE;
      bus_idle_q <= 1'b1;
      scl_q <= 1'b1;
      sda_low_q <= 1'b0;
      div_q <= '0;
      ph_q <= 2'h0;
    end
    else
    begin
      st_q <= st_d;
      bus_idle_q <= st_d == C_IDLE;
      scl_q <= scl_d;
      sda_low_q <= sda_low_d;
      div_q <= (take || tick) ? '0 : DW'(div_q + 1'b1);
      ph_q <= take ? 2'h0 : (tick ? 2'(ph_q + 2'h1) : ph_q);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      bit_q <= 4'h0;
      rec_q <= 4'h0;
      sh_q <= 8'h00;
    end
    else if (take)
    begin
      bit_q <= 4'h0;
      rec_q <= 4'h0;
      sh_q <= cmd_byte;
    end
    else if (ph_end && st_q == C_START)
      bit_q <= 4'h0;
    else if (ph_end && st_q == C_BIT)
    begin
      bit_q <= 4'(bit_q + 4'h1);
      sh_q <= {sh_q[6:0], 1'b0};
    end
    else if (ph_end && st_q == C_RECOV)
      rec_q <= 4'(rec_q + 4'h1);
  end

  // Answer: acknowledge seen, stop finished, recovery failed, or refused command
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rsp_valid_q <= 1'b0;
      rsp_ack_q <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= nack_cmd | (ph_end & ((st_q == C_BIT & last_bit) | st_q == C_STOP
        | (st_q == C_RECOV & ~sda_s & rec_end)));
      if (ph_end && st_q == C_BIT && last_bit)
        rsp_ack_q <= ~sda_s;
      else if (ph_end && st_q == C_STOP)
        rsp_ack_q <= 1'b1;
      else if (nack_cmd || ph_end)
        rsp_ack_q <= 1'b0;
    end
  end

  assign cmd_ready = (st_q == C_IDLE) | held;
  assign rsp_valid = rsp_valid_q;
  assign rsp_ack = rsp_ack_q;
  assign bus_idle = bus_idle_q;
  assign bus.scl = scl_q;
  assign bus.ctl_sda_o = 1'b0;
  assign bus.ctl_sda_oe_n = ~sda_low_q;
endmodule // sew_bus_ctl
`default_nettype wire

// ---- rtl/sew_eeprom_dev.sv ----
// Two-wire EEPROM target end: address match, page write buffer, timed program
// Overview of operation
// - Data falling while clock high starts transfer
// - Data rising while clock high stops transfer
// - Data changes only with clock low
// - Sample on clock rise, drive on fall
// - Eight-bit words, acknowledge on ninth clock
// - Device address word follows every start
// - 2K: three bits match all selects
// - 4K: two bits match, one page bit
// - 8K: one bit matches, two page bits
// - 16K: page bits only, address upper bits
// - Eighth bit chooses read or write
// - Acknowledge match, otherwise silent and standby
// - Word address width eight to eleven bits
// - Byte write: address, word address, data, stop
// - Stop launches timed program, inputs ignored
// - Page write takes up to page bytes
// - Only low address bits increment, page wraps
// - Poll acknowledged only after program ends
// - Protect input high blocks all writes
// - Standby at reset, after a stop that launches no program, and when the timed program ends
// - Controller recovers bus by clocking up to nine times, stopping once data is high
`timescale 1ns/1ps
`default_nettype none
module sew_eeprom_dev #(
  parameter int VARIANT = sew_pkg::VARIANT_2K,
  parameter int PROG_CYCLES = sew_pkg::PROG_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  sew_if.dev bus,
  input wire logic chip_select_bit_low,
  input wire logic chip_select_bit_mid,
  input wire logic chip_select_bit_high,
  input wire logic write_protect,
  input wire logic [sew_pkg::MAX_ADDR_BITS-1:0] rd_addr,
  output logic [7:0] rd_data,
  output logic standby,
  output logic prog_busy
);
  import sew_pkg::*;

  localparam int AW = BASE_ADDR_BITS + VARIANT;
  localparam int PW = (VARIANT == VARIANT_2K) ? PAGE_BITS_2K : PAGE_BITS_WIDE;
  localparam int PB = 1 << PW;
  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam logic [2:0] CS_MASK = 3'(3'h7 << VARIANT);

  generate
    if (VARIANT < VARIANT_2K || VARIANT > VARIANT_16K || PROG_CYCLES < 1)
    begin : g_bad_param
      $error("sew_eeprom_dev: unsupported VARIANT or PROG_CYCLES");
    end
  endgenerate

  sew_dst_t st_q;
  sew_dst_t st_d;
  logic [5:0] pin_s;
  logic scl_p_q;
  logic sda_p_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic ack_q;
  logic [AW-1:0] addr_q;
  logic [PB-1:0] pval_q;
  logic [7:0] pbuf_q [PB];
  logic [TW-1:0] tmr_q;
  logic [7:0] mem_q [1 << AW];
  logic [7:0] rd_data_q;
  logic standby_q;
  logic prog_busy_q;

  // Pins cross into the system clock before any logic looks at them
  sew_sync #(.W(6), .INIT(DEV_PIN_INIT)) u_pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d({bus.scl, bus.sda, write_protect, chip_select_bit_high, chip_select_bit_mid,
      chip_select_bit_low}),
    .q(pin_s)
  );

  wire scl_s = pin_s[5];
  wire sda_s = pin_s[4];
  wire wp_s = pin_s[3];
  wire [2:0] cs_v = pin_s[2:0];

  // Edge and condition decode
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire rx_state = (st_q == D_DEVADR) | (st_q == D_WORDADR) | (st_q == D_DATA);
  wire bit_in = rx_state & scl_rise & (cnt_q < ACK_BIT_IDX);
  wire ack_rise = scl_rise & (cnt_q == ACK_BIT_IDX);
  wire byte_done = rx_state & scl_fall & (cnt_q == ACK_BIT_IDX);
  wire ack_end = scl_fall & (cnt_q == ACK_END_IDX);

  // Device address match
  wire type_ok = sh_q[7:4] == DEV_TYPE_CODE;
  wire cs_ok = ((sh_q[3:1] ^ cs_v) & CS_MASK) == 3'h0;
  wire dev_match = type_ok & cs_ok;
  wire is_read = sh_q[0];
  wire ack_take = (st_q == D_DEVADR) ? dev_match : 1'b1;

  // Page buffer and program control
  wire [PW-1:0] wr_idx = addr_q[PW-1:0];
  wire pend = |pval_q;
  wire in_prog = st_q == D_PROG;
  wire prog_done = in_prog & (tmr_q == TW'(PROG_CYCLES - 1));
  wire prog_go = stop_ev & (st_q == D_DATA) & pend & ~wp_s;

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      D_PROG:
      begin
        if (prog_done)
          st_d = D_IDLE;
      end
      D_IDLE, D_DEVADR, D_WORDADR, D_DATA, D_READ:
      begin
        if (start_ev)
          st_d = D_DEVADR;
        else if (stop_ev)
          st_d = prog_go ? D_PROG : D_IDLE;
        else if (byte_done && st_q == D_DEVADR && !dev_match)
          st_d = D_IDLE;
        else if (byte_done && st_q == D_DEVADR)
          st_d = is_read ? D_READ : D_WORDADR;
        else if (byte_done && st_q == D_WORDADR)
          st_d = D_DATA;
      end
      default:
        st_d = D_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_q <= D_IDLE;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      standby_q <= 1'b1;
      prog_busy_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      standby_q <= st_d == D_IDLE;
      prog_busy_q <= st_d == D_PROG;
    end
  end

  // Bit counter: eight data clocks, then the acknowledge clock
  always_ff @(posedge clk_sys)
  begin
    if (rst || in_prog || start_ev || stop_ev)
      cnt_q <= 4'h0;
    else if (bit_in || ack_rise)
      cnt_q <= 4'(cnt_q + 4'h1);
    else if (ack_end)
      cnt_q <= 4'h0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      sh_q <= 8'h00;
    else if (bit_in)
      sh_q <= {sh_q[6:0], sda_s};
  end

  // Acknowledge is driven and released on clock falls
  always_ff @(posedge clk_sys)
  begin
    if (rst || in_prog || start_ev || stop_ev)
      ack_q <= 1'b0;
    else if (byte_done)
      ack_q <= ack_take;
    else if (ack_end)
      ack_q <= 1'b0;
  end

  // Word address: page bits from the device word, low bits wrap in the page
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      addr_q <= '0;
    else if (byte_done && st_q == D_DEVADR && dev_match)
    begin
      for (int i = 0; i < VARIANT; i++)
        addr_q[BASE_ADDR_BITS + i] <= sh_q[1 + i];
    end
    else if (byte_done && st_q == D_WORDADR)
      addr_q[BASE_ADDR_BITS-1:0] <= sh_q;
    else if (byte_done && st_q == D_DATA)
      addr_q[PW-1:0] <= PW'(wr_idx + 1'b1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || prog_done)
      pval_q <= '0;
    else if (byte_done && st_q == D_WORDADR)
      pval_q <= '0;
    else if (byte_done && st_q == D_DATA)
      pval_q[wr_idx] <= 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (byte_done && st_q == D_DATA)
      pbuf_q[wr_idx] <= sh_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || !in_prog)
      tmr_q <= '0;
    else
      tmr_q <= TW'(tmr_q + 1'b1);
  end

  // Array update at the end of the program cycle; read port for inspection
  always_ff @(posedge clk_sys)
  begin
    if (prog_done)
    begin
      for (int i = 0; i < PB; i++)
      begin
        if (pval_q[i])
          mem_q[{addr_q[AW-1:PW], PW'(i)}] <= pbuf_q[i];
      end
    end
    rd_data_q <= mem_q[rd_addr[AW-1:0]];
  end

  assign rd_data = rd_data_q;
  assign standby = standby_q;
  assign prog_busy = prog_busy_q;
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe_n = ~ack_q;
endmodule // sew_eeprom_dev
`default_nettype wire

// ---- tb/sew_link_assertions.sv ----
// Checker watching the two-wire link between the EEPROM end and the controller end
`timescale 1ns/1ps
`default_nettype none
module sew_link_assertions #(
  parameter int QUARTER_CYC = 10
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic ctl_sda_o,
  input wire logic ctl_sda_oe_n
);
  localparam int ACK_LO = 4 * QUARTER_CYC - 4;
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [3:0] low_q;
  logic [3:0] low_d;
  wire start_w = scl && scl_q && sda_q && !sda;
  wire stop_w = scl && scl_q && !sda_q && sda;
  wire rise_w = scl && !scl_q;
  // Clock rises since the last start, wrapping after the ninth
  assign bit_d = start_w ? 4'h0 : !rise_w ? bit_q : (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
  // Cycles since the clock fell, saturating; full while the clock is high
  assign low_d = scl ? 4'hf : scl_q ? 4'h0 : (low_q == 4'hf) ? low_q : low_q + 4'h1;
  always_ff @(posedge clk_sys)
  begin
    scl_q <= rst ? 1'h1 : scl;
    sda_q <= rst ? 1'h1 : sda;
    bit_q <= rst ? 4'h0 : bit_d;
    low_q <= rst ? 4'hf : low_d;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  AST_ACK_ON_NINTH: assert property ($fell(dev_sda_oe_n) |-> bit_q == 4'h8)
    else $error("device pulled data outside the ninth clock");
  AST_DEV_CHANGE_SCL_LOW: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device changed data while clock high");
  AST_DEV_DRIVE_ON_FALL: assert property ($changed(dev_sda_oe_n) |-> low_q <= 4'h8)
    else $error("device output not updated just after clock fall");
  AST_ACK_ONE_BIT: assert property ($fell(dev_sda_oe_n) |->
    (!dev_sda_oe_n throughout ##ACK_LO 1'b1) ##[1:8] dev_sda_oe_n)
    else $error("acknowledge not held for exactly one clock");
  AST_START_SILENT: assert property (start_w |-> dev_sda_oe_n [*8])
    else $error("device drove data right after start");
  AST_STOP_SILENT: assert property (stop_w |=> dev_sda_oe_n [*8])
    else $error("device drove data right after stop");
  AST_DEV_PULLS_LOW: assert property (!dev_sda_oe_n |-> !dev_sda_o && !sda)
    else $error("device drive does not pull data low");
  AST_RESET_IDLE: assert property ($fell(rst) |-> scl && ctl_sda_oe_n && dev_sda_oe_n)
    else $error("link not idle after reset");
  AST_CTL_CHANGE_IS_COND: assert property ($changed(ctl_sda_oe_n) && scl |->
    start_w || stop_w)
    else $error("controller changed data with clock high outside start or stop");
  AST_CTL_PULLS_LOW: assert property (!ctl_sda_oe_n |-> !ctl_sda_o && !sda)
    else $error("controller drive does not pull data low");
  cover property (start_w ##[1:400] $fell(dev_sda_oe_n));
endmodule // sew_link_assertions
`default_nettype wire

// ---- tb/serial_eeprom_bus_write_path_tb.sv ----
// Bench joining the EEPROM end and the controller end over one link
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_bus_write_path_tb;
  import sew_pkg::*;
  localparam int QC = 10;
  localparam int PC = 1000;
  typedef struct packed {sew_op_t op; logic [7:0] b; logic ack;} sew_row_t;
  logic clk_sys, rst, cmd_valid, cmd_ready, rsp_valid, rsp_ack, bus_idle, ack;
  logic chip_select_bit_low, chip_select_bit_mid, chip_select_bit_high;
  logic write_protect, standby, prog_busy;
  sew_op_t cmd_op;
  logic [7:0] cmd_byte, rd_data, got;
  logic [10:0] rd_addr;
  int n_errors, cmp_count, i;
  // Selects 101: own write address aa; 0..7 writes, 8..11 protected, 12.. odd cases
  sew_row_t rows [19] = '{'{OP_START, 8'ha0, 1'b0}, '{OP_START, 8'hae, 1'b0},
    '{OP_START, 8'haa, 1'b1}, '{OP_BYTE, 8'h1e, 1'b1}, '{OP_BYTE, 8'h11, 1'b1},
    '{OP_BYTE, 8'h22, 1'b1}, '{OP_BYTE, 8'h33, 1'b1}, '{OP_STOP, 8'h00, 1'b1},
    '{OP_START, 8'haa, 1'b1}, '{OP_BYTE, 8'h1e, 1'b1}, '{OP_BYTE, 8'h44, 1'b1},
    '{OP_STOP, 8'h00, 1'b1}, '{OP_START, 8'hab, 1'b1}, '{OP_STOP, 8'h00, 1'b1},
    '{OP_BYTE, 8'h00, 1'b0}, '{OP_START, 8'haa, 1'b1}, '{OP_BYTE, 8'h05, 1'b1},
    '{OP_RECOVER, 8'haa, 1'b1}, '{OP_STOP, 8'h00, 1'b1}};
  sew_if bus ();
  sew_eeprom_dev #(.VARIANT(VARIANT_2K), .PROG_CYCLES(PC)) sew_eeprom_dev_i (.clk_sys(clk_sys),
    .rst(rst), .bus(bus), .chip_select_bit_low(chip_select_bit_low),
    .chip_select_bit_mid(chip_select_bit_mid), .chip_select_bit_high(chip_select_bit_high),
    .write_protect(write_protect), .rd_addr(rd_addr), .rd_data(rd_data), .standby(standby),
    .prog_busy(prog_busy));
  sew_bus_ctl #(.QUARTER_CYC(QC)) sew_bus_ctl_i (.clk_sys(clk_sys), .rst(rst), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_byte(cmd_byte),
    .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .bus_idle(bus_idle));
  sew_link_assertions #(.QUARTER_CYC(QC)) sew_link_assertions_i (.clk_sys(clk_sys), .rst(rst),
    .scl(bus.scl), .sda(bus.sda), .dev_sda_o(bus.dev_sda_o), .dev_sda_oe_n(bus.dev_sda_oe_n),
    .ctl_sda_o(bus.ctl_sda_o), .ctl_sda_oe_n(bus.ctl_sda_oe_n));
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One controller command, held across the accepting edge, answer awaited
  task run(input sew_op_t op, input logic [7:0] b, output logic a);
    int k;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 3000)
    begin
      @(negedge clk_sys);
      k++;
    end
    cmd_op = op;
    cmd_byte = b;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 3000)
    begin
      @(negedge clk_sys);
      k++;
    end
    if (rsp_valid !== 1'b1)
      chk({7'h0, rsp_valid}, 8'h01);
    a = (rsp_valid === 1'b1) ? rsp_ack : 1'bx;
    @(negedge clk_sys);
  endtask
  task play(input int lo, input int hi);
    for (int r = lo; r <= hi; r++)
    begin
      run(rows[r].op, rows[r].b, ack);
      chk({7'h0, ack}, {7'h0, rows[r].ack});
    end
  endtask
  task peek(input logic [10:0] a, output logic [7:0] d);
    rd_addr = a;
    @(negedge clk_sys);
    @(negedge clk_sys);
    d = rd_data;
  endtask
  initial
  begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_START;
    cmd_byte = 8'h00;
    chip_select_bit_low = 1'b1;
    chip_select_bit_mid = 1'b0;
    chip_select_bit_high = 1'b1;
    write_protect = 1'b0;
    rd_addr = 11'h000;
    n_errors = 0;
    cmp_count = 0;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    chk({4'h0, cmd_ready, standby, prog_busy, bus_idle}, 8'h0d);
    play(0, 7);
    repeat (8) @(negedge clk_sys);
    chk({6'h0, prog_busy, standby}, 8'h02);
    run(OP_START, 8'haa, ack);
    chk({7'h0, ack}, 8'h00);
    i = 0;
    while (ack !== 1'b1 && i < 10)
    begin
      run(OP_START, 8'haa, ack);
      i++;
    end
    chk({7'h0, ack, prog_busy}, 8'h02);
    run(OP_STOP, 8'h00, ack);
    peek(11'h01e, got);
    chk(got, 8'h11);
    peek(11'h01f, got);
    chk(got, 8'h22);
    peek(11'h018, got);
    chk(got, 8'h33);
    write_protect = 1'b1;
    play(8, 11);
    repeat (20) @(negedge clk_sys);
    chk({6'h0, prog_busy, standby}, 8'h01);
    peek(11'h01e, got);
    chk(got, 8'h11);
    write_protect = 1'b0;
    play(12, 18);
    chk({6'h0, standby, bus_idle}, 8'h03);
    // Reset in the middle of a program cycle
    run(OP_START, 8'haa, ack);
    run(OP_BYTE, 8'h1e, ack);
    run(OP_BYTE, 8'h55, ack);
    run(OP_STOP, 8'h00, ack);
    chk({7'h0, prog_busy}, 8'h01);
    rst = 1'b1;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    chk({4'h0, cmd_ready, standby, prog_busy, bus_idle}, 8'h0d);
    run(OP_START, 8'haa, ack);
    chk({7'h0, ack}, 8'h01);
    run(OP_STOP, 8'h00, ack);
    chk({6'h0, standby, bus_idle}, 8'h03);
    conclude();
  end
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    conclude();
  end
endmodule // serial_eeprom_bus_write_path_tb
`default_nettype wire
